// File: seer_read_path.sv
// serial eeprom read path: link slave, shared counter and special spaces
`timescale 1ns/10ps
`default_nettype none

module seer_read_path #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // two-wire link pins
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    // straps and status from the rest of the device
    input  wire logic [2:0]        chip_select_i,
    input  wire logic              write_protect_i,
    input  wire logic              write_busy_i,
    input  wire logic              ident_locked_i,
    input  wire logic [1:0]        protect_size_i,
    // array and ident page read port, data same cycle as address
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic                   mem_ident_o,
    input  wire logic [7:0]        mem_data_i,
    // serial number block, 16 bytes, read only
    input  wire logic [127:0]      serial_number_i,
    // counter load to the write side
    output logic                   addr_load_o,
    output logic [ADDR_W-1:0]      addr_val_o
);
    // counter arithmetic and space decode assume a 16 bit word address
    if (ADDR_W != 16) begin : g_bad_width
        $error("seer_read_path: ADDR_W must be 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // overview
    // link side runs entirely off ref_clk_i; scl and sda are pins,
    // so both pass two flops before any decode looks at them
    // a third stage of history gives the scl edges and the
    // start and stop conditions (sda moving while scl stays high)
    //
    // one transfer, as seen from this block:
    //   start          -> shift in the device address byte
    //   8th scl rise   -> byte complete, decided on the next scl fall
    //   good address   -> pull sda low for one bit (our ack)
    //   rw bit low     -> take two word address bytes, high first
    //   rw bit high    -> put the byte at the counter on sda
    //   9th bit        -> master ack asks for the next byte
    //   master nack    -> back to standby, stop then follows
    //
    // address spaces behind the device type codes:
    //   plain type     -> main array, full 16 bit counter
    //   special type   -> space chosen by two word address bits
    //     ident page   -> seven bit offset, wraps inside the page
    //     serial block -> four bit offset, wraps after 16 bytes
    //     protection   -> size bits, same byte for every read
    //     lock status  -> data byte always refused; the lock probe is acked on the ident page
    //
    // the counter is shared by array, ident page and serial block;
    // a current-address read after a special access therefore
    // starts from the offset that access left behind
    //
    // the counter has no reset value: it only ever comes from a
    // word address, so a link reset must not disturb it
    //
    // write protect and protection size never gate a read;
    // the pin is accepted only to keep the port list complete
    //
    // no ack while the self-timed write runs: polling masters
    // see a refused device address byte until it is over
    //
    // data bits change about three ref clocks after the scl fall
    // is seen; the master must keep scl low for longer than that
    // (limitation: scl low and high phases of at least four
    // ref clocks each are needed for clean sampling)
    //
    // sda_o is tied low: open drain, the enable carries the level
    //
    // a start in any state aborts the transfer, which is how a
    // truncated lock probe is thrown away before it could write
    //
    // mem_data_i must answer in the same cycle as mem_addr_o;
    // trade-off: no read pipeline, so the array sits on a short path

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [2:0]          scl_s;    // scl sync plus history
        logic [2:0]          sda_s;
        seer_pkg::seer_state_e st;
        logic [3:0]          bits;
        logic [7:0]          sh;
        logic                dev_spec; // type 1011 addressed
        logic [ADDR_W-1:0]   cnt;      // shared counter
        logic [ADDR_W-1:0]   ahi;
        logic [1:0]          space;
        logic                do_ack;   // slave drives ack this bit
        logic                ack_sent;
        logic                sda_q;
        logic                sda_oe;
        logic                load;
    } seer_s;

    seer_s s_q;
    seer_s s_d;

    // read data selection across spaces, protection byte repeats itself
    function automatic logic [7:0] seer_rbyte(input logic spec,
            input logic [1:0] sp, input logic [15:0] a,
            input logic [7:0] md, input logic [127:0] sn,
            input logic [1:0] ps);
        logic [7:0] r;
        r = md;
        if (spec && sp == seer_pkg::SEER_SP_PROT) begin
            r = {6'h00, ps};
        end else if (spec && sp == seer_pkg::SEER_SP_SERIAL) begin
            r = sn[8'(127 - 8 * a[3:0]) -: 8];      // byte 0 is msbyte
        end
        return r;
    endfunction : seer_rbyte

    // counter advance with per-space wrap
    function automatic logic [15:0] seer_next(input logic spec,
            input logic [1:0] sp, input logic [15:0] a);
        logic [15:0] n;
        n = a + 16'h0001;                           // wraps at top
        if (spec && sp == seer_pkg::SEER_SP_IDENT) begin
            n = (a & ~seer_pkg::SEER_IDENT_MSK)
                | (n & seer_pkg::SEER_IDENT_MSK);
        end else if (spec && sp == seer_pkg::SEER_SP_SERIAL) begin
            n = (a & ~seer_pkg::SEER_SER_MSK)
                | (n & seer_pkg::SEER_SER_MSK);
        end else if (spec && sp == seer_pkg::SEER_SP_PROT) begin
            n = a;
        end
        return n;
    endfunction : seer_next

    logic scl_rise;
    logic scl_fall;
    logic sda_b;
    logic start_c;
    logic stop_c;
    logic [7:0] byte_in;
    logic [7:0] rb;
    // word address bit where the space select field starts
    localparam int SEER_SPB = seer_pkg::SEER_SP_LSB;

    ////////////////////////////////////////////////////////////////////////
    // edge and condition detect; bit 0 of each sync is first stage only
    assign scl_rise = s_q.scl_s[1] & ~s_q.scl_s[2];
    assign scl_fall = ~s_q.scl_s[1] & s_q.scl_s[2];
    assign sda_b    = s_q.sda_s[1];
    assign start_c  = s_q.scl_s[1] & s_q.scl_s[2] & s_q.sda_s[2] & ~sda_b;
    assign stop_c   = s_q.scl_s[1] & s_q.scl_s[2] & ~s_q.sda_s[2] & sda_b;
    assign byte_in  = {s_q.sh[6:0], sda_b};
    // write protect and protect size never gate a read
    assign rb = seer_rbyte(s_q.dev_spec, s_q.space, s_q.cnt, mem_data_i,
                           serial_number_i, protect_size_i);

    ////////////////////////////////////////////////////////////////////////
    // next state
    // decode order: start first, then stop, then scl edges;
    // a start or stop always wins over a bit in flight
    // scl rise: sample a bit, or the master's ack in its slot
    // scl fall: move sda for the next bit, or decide a byte
    // do_ack marks a bit slot in which this block pulls sda;
    // the scl rise inside that slot carries no data
    // bits counts scl rises within the current byte, 0 to 8
    // sh holds the incoming byte, or the outgoing one in a read
    // hazard: the next read byte is fetched at the fall that
    // ends the master ack, after the counter has moved on
    // the first read byte is fetched at the fall that ends
    // our own ack of the device address byte
    // refused bytes drop to standby and ignore the bus until
    // the next start
    always_comb begin
        s_d       = s_q;
        s_d.scl_s = {s_q.scl_s[1:0], scl_i};
        s_d.sda_s = {s_q.sda_s[1:0], sda_i};
        s_d.load  = 1'b0;
        if (start_c) begin
            // start drops any pending truncated write
            s_d.st     = seer_pkg::SEER_DEV;
            s_d.bits   = 4'h0;
            s_d.do_ack = 1'b0;
            s_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            s_d.st     = seer_pkg::SEER_IDLE;
            s_d.sda_oe = 1'b0;
            s_d.do_ack = 1'b0;
        end else if (s_q.st != seer_pkg::SEER_IDLE) begin
            if (scl_rise && !s_q.do_ack) begin
                if (s_q.st == seer_pkg::SEER_MACK) begin
                    if (sda_b) begin
                        s_d.st = seer_pkg::SEER_IDLE;   // nack: wait stop
                    end else begin
                        s_d.st = seer_pkg::SEER_RDAT;
                    end
                    s_d.bits = 4'h0;
                end else if (s_q.st != seer_pkg::SEER_RDAT) begin
                    s_d.sh   = byte_in;
                    s_d.bits = s_q.bits + 4'h1;
                end else begin
                    s_d.bits = s_q.bits + 4'h1;
                end
            end
            if (scl_fall) begin
                if (s_q.do_ack) begin
                    // ack bit over, release and go on
                    s_d.do_ack = 1'b0;
                    s_d.sda_oe = 1'b0;
                    s_d.bits   = 4'h0;
                    if (s_q.st == seer_pkg::SEER_RDAT) begin
                        s_d.sda_oe = ~rb[7];
                        s_d.sh     = rb;
                    end
                end else if (s_q.st == seer_pkg::SEER_RDAT) begin
                    if (s_q.bits == 4'h0) begin
                        // master acked: fetch and start the next byte
                        s_d.sda_oe = ~rb[7];
                        s_d.sh     = rb;
                    end else if (s_q.bits == seer_pkg::SEER_BIT_LAST) begin
                        s_d.sda_oe = 1'b0;
                        s_d.st     = seer_pkg::SEER_MACK;
                        s_d.cnt    = seer_next(s_q.dev_spec, s_q.space,
                                               s_q.cnt);
                    end else begin
                        s_d.sda_oe = ~s_q.sh[3'(7 - s_q.bits)];
                    end
                end else if (s_q.bits == seer_pkg::SEER_BIT_LAST) begin
                    s_d.bits = 4'h0;
                    case (s_q.st)
                        seer_pkg::SEER_DEV: begin
                            // type, select strap and busy decide the ack
                            if ((s_q.sh[7:4] == seer_pkg::SEER_TYPE_ARRAY
                                 || s_q.sh[7:4] == seer_pkg::SEER_TYPE_SPEC)
                                && s_q.sh[3:1] == chip_select_i
                                && !write_busy_i) begin
                                s_d.do_ack   = 1'b1;
                                s_d.sda_oe   = 1'b1;
                                s_d.dev_spec = (s_q.sh[7:4]
                                    == seer_pkg::SEER_TYPE_SPEC);
                                s_d.st = s_q.sh[0] ? seer_pkg::SEER_RDAT
                                                   : seer_pkg::SEER_AHI;
                            end else begin
                                s_d.st = seer_pkg::SEER_IDLE;
                            end
                        end
                        seer_pkg::SEER_AHI: begin
                            s_d.ahi    = {s_q.sh, 8'h00};
                            s_d.do_ack = 1'b1;
                            s_d.sda_oe = 1'b1;
                            s_d.st     = seer_pkg::SEER_ALO;
                        end
                        seer_pkg::SEER_ALO: begin
                            // dummy write sets the shared counter, except in protection and lock space where it keeps its value
                            s_d.space  = s_q.ahi[SEER_SPB +: 2];
                            if (!s_q.dev_spec) begin
                                s_d.cnt = s_q.ahi | {8'h00, s_q.sh};
                            end else if (s_q.ahi[SEER_SPB +: 2]
                                         == seer_pkg::SEER_SP_IDENT) begin
                                s_d.cnt = {9'h000, s_q.sh[6:0]};
                            end else if (s_q.ahi[SEER_SPB +: 2]
                                         == seer_pkg::SEER_SP_SERIAL) begin
                                s_d.cnt = {12'h000, s_q.sh[3:0]};
                            end
                            s_d.load   = 1'b1;
                            s_d.do_ack = 1'b1;
                            s_d.sda_oe = 1'b1;
                            s_d.st     = seer_pkg::SEER_WDAT;
                        end
                        seer_pkg::SEER_WDAT: begin
                            // only the ident page probe is acked here;
                            // serial block takes no data at all
                            if (s_q.dev_spec && s_q.space
                                    == seer_pkg::SEER_SP_IDENT
                                && !ident_locked_i) begin
                                s_d.do_ack = 1'b1;
                                s_d.sda_oe = 1'b1;
                            end else begin
                                s_d.st = seer_pkg::SEER_IDLE;
                            end
                        end
                        default: begin
                            s_d.st = seer_pkg::SEER_IDLE;
                        end
                    endcase
                end
            end
        end
        s_d.sda_q = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; counter has no reset path so it survives link resets
    // sync stages reset to the idle high level of both pins, so
    // no false scl edge or start is seen right after reset
    // the counter keeps its own next value during reset: in
    // simulation it stays unknown until the first word address
    // trade-off: one field of the struct escapes the reset, which
    // keeps the counter alive across a link-only reset
    // all other fields start in standby with sda released
    // reset is synchronous, so it needs at least one clock edge
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q.scl_s    <= 3'h7;
            s_q.sda_s    <= 3'h7;
            s_q.st       <= seer_pkg::SEER_IDLE;
            s_q.bits     <= 4'h0;
            s_q.sh       <= 8'h00;
            s_q.dev_spec <= 1'b0;
            s_q.ahi      <= 16'h0000;
            s_q.space    <= 2'h0;
            s_q.do_ack   <= 1'b0;
            s_q.ack_sent <= 1'b0;
            s_q.sda_q    <= 1'b0;
            s_q.sda_oe   <= 1'b0;
            s_q.load     <= 1'b0;
            s_q.cnt      <= s_d.cnt;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; open drain, enable high pulls low
    // every output but mem_ident_o comes straight from a register, so the pin
    // never glitches while the next state settles
    // the counter is shown both to the array and to the write
    // side, which picks it up on the load pulse
    assign sda_o       = s_q.sda_q;
    assign sda_oe_o    = s_q.sda_oe;
    assign mem_addr_o  = s_q.cnt;
    assign mem_ident_o = s_q.dev_spec
                         & (s_q.space == seer_pkg::SEER_SP_IDENT);
    assign addr_load_o = s_q.load;
    assign addr_val_o  = s_q.cnt;
    logic unused_wp;
    assign unused_wp = write_protect_i ^ s_q.ack_sent;
endmodule : seer_read_path

`default_nettype wire

// File: seer_pkg.sv
// constants, types and behaviour summary for the serial eeprom read path
// Behaviour
// - read starts with Start, type 1010/1011, matching select bits, rw=1; then ack
// - reads ignore write-protect pin and block protection register contents
// - current-address read acks, sends byte at counter, then increments counter
// - address counter keeps its value between operations while powered
// - array reads wrap from last byte of last page to byte zero
// - one counter shared by array, ident page and serial number accesses
// - after read ack, send byte, increment counter, continue while acked
// - sequential read continues until nack followed by Stop
// - ident page read: type 1011, space bits 00, low seven bits select byte
// - ident page reads wrap within the 128-byte page
// - lock probe data byte acked if page unlocked, refused if locked
// - Start after probe discards the truncated write; Stop returns to standby
// - protection read: type 1011, space 11, returns six zeros and size bits
// - further protection register bytes repeat the same value
// - serial number read: type 1011, space 01, low four bits select byte
// - serial number reads wrap after the sixteenth byte
// - serial number block is never writable
// - size bits: 00 none, 01 upper quarter, 10 upper half, 11 whole
// - no ack of device address byte during a self-timed write cycle
package seer_pkg;
    localparam logic [3:0] SEER_TYPE_ARRAY = 4'ha;
    localparam logic [3:0] SEER_TYPE_SPEC  = 4'hb;
    localparam logic [1:0] SEER_SP_IDENT   = 2'h0;
    localparam logic [1:0] SEER_SP_SERIAL  = 2'h1;
    localparam logic [1:0] SEER_SP_LOCK    = 2'h2;
    localparam logic [1:0] SEER_SP_PROT    = 2'h3;
    localparam int         SEER_SP_LSB     = 9;
    localparam logic [15:0] SEER_ADDR_RST  = 16'h0000;
    localparam logic [15:0] SEER_IDENT_MSK = 16'h007f;
    localparam logic [15:0] SEER_SER_MSK   = 16'h000f;
    localparam logic [3:0]  SEER_BIT_LAST  = 4'h8;

    typedef enum logic [6:0] {
        SEER_IDLE  = 7'h01,  // standby, waiting for Start
        SEER_DEV   = 7'h02,  // shifting in device address byte
        SEER_AHI   = 7'h04,  // shifting in address high byte
        SEER_ALO   = 7'h08,  // shifting in address low byte
        SEER_WDAT  = 7'h10,  // shifting in write data (probe only)
        SEER_RDAT  = 7'h20,  // shifting out read data
        SEER_MACK  = 7'h40   // sampling master ack
    } seer_state_e;
endpackage : seer_pkg

// File: seer_read_path_chk.sv
// port assertions for the serial eeprom read path
`timescale 1ns/10ps
`default_nettype none
module seer_read_path_chk #(
    parameter int ADDR_W = 16
) (
    // clock, reset and watched ports
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              scl_i,
    input  wire logic              sda_o,
    input  wire logic              sda_oe_o,
    input  wire logic              write_busy_i,
    input  wire logic [ADDR_W-1:0] mem_addr_o,
    input  wire logic              addr_load_o
);
    logic [5:0] hi_cnt_q;
    logic [5:0] busy_cnt_q;
    logic       loaded_q;
    // saturating spans; counter is x until its first load
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hi_cnt_q   <= 6'h00;
            busy_cnt_q <= 6'h00;
            loaded_q   <= 1'b0;
        end else begin
            hi_cnt_q   <= scl_i ?
                          hi_cnt_q + {5'h00, hi_cnt_q != 6'h3f} : 6'h00;
            busy_cnt_q <= write_busy_i ?
                          busy_cnt_q + {5'h00, busy_cnt_q != 6'h3f} : 6'h00;
            loaded_q   <= loaded_q | addr_load_o;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_sda_drive_low: assert property (
        sda_o == 1'b0)
        else $error("sda data value not low");
    a_oe_in_reset: assert property (
        disable iff (1'b0) !rst_n_i |=> !sda_oe_o)
        else $error("sda driven during reset");
    a_oe_stands: assert property (
        $rose(sda_oe_o) |=> sda_oe_o)
        else $error("sda pull too short");
    a_load_pulse: assert property (
        addr_load_o |=> !addr_load_o [*8])
        else $error("address load not a lone pulse");
    a_idle_release: assert property (
        hi_cnt_q >= 6'd24 |-> !sda_oe_o)
        else $error("sda held while bus idle");
    a_busy_no_ack: assert property (
        busy_cnt_q >= 6'd16 |-> !sda_oe_o)
        else $error("ack given during write cycle");
    a_busy_no_load: assert property (
        busy_cnt_q >= 6'd16 |-> !addr_load_o)
        else $error("address loaded during write cycle");
    a_addr_held: assert property (
        loaded_q && hi_cnt_q >= 6'd24 |-> $stable(mem_addr_o))
        else $error("counter moved while idle");
endmodule : seer_read_path_chk
bind seer_read_path seer_read_path_chk #(.ADDR_W(ADDR_W)) i_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .write_busy_i(write_busy_i),
    .mem_addr_o(mem_addr_o), .addr_load_o(addr_load_o));
`default_nettype wire

// File: seer_mst_model.sv
// two-wire bus master model: frames, bytes and acks
`timescale 1ns/10ps
`default_nettype none
module seer_mst_model (
    // clock
    input  wire logic ref_clk_i,
    // bus
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    // link clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wait_clk
    // one bit of 320 ns; sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        wait_clk(1);
        sda_o = b;
        wait_clk(5);
        scl_o = 1'b1;
        wait_clk(2);
        s = sda_i;
        scl_o = 1'b0;
    endtask : bit_io
    // wait lets the device drop its last pull first
    task automatic start_c();
        sda_o = 1'b1;
        wait_clk(6);
        scl_o = 1'b1;
        wait_clk(4);
        sda_o = 1'b0;
        wait_clk(4);
        scl_o = 1'b0;
    endtask : start_c
    task automatic stop_c();
        sda_o = 1'b0;
        wait_clk(6);
        scl_o = 1'b1;
        wait_clk(4);
        sda_o = 1'b1;
        wait_clk(4);
    endtask : stop_c
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wbyte
    task automatic rbyte(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!ack, s);
    endtask : rbyte
endmodule : seer_mst_model
`default_nettype wire

// File: seer_read_path_tb.sv
// self-checking bench for the serial eeprom read path
`timescale 1ns/10ps
`default_nettype none
module seer_read_path_tb;
    logic         ref_clk_i = 1'b0;
    logic         rst_n_i = 1'b0;
    logic [2:0]   cs = 3'h5;
    logic         wp = 1'b0;
    logic         busy = 1'b0;
    logic         locked = 1'b0;
    logic [1:0]   ps = 2'h0;
    logic [127:0] sn = '0;
    logic [15:0]  maddr, ad;
    logic [3:0]   t;
    logic         mid, sda_oe, scl, msda, sda_w, a;
    logic [7:0]   rd;
    logic         ld;
    logic [15:0]  av, av_seen;
    integer       errors = 0, n_tests = 0, seed = 32'h9e592aa5;
    localparam logic [3:0] TA = seer_pkg::SEER_TYPE_ARRAY;
    localparam logic [3:0] TB = seer_pkg::SEER_TYPE_SPEC;
    always #20 ref_clk_i = ~ref_clk_i;
    // open drain wire with pull-up
    assign sda_w = msda & ~sda_oe;
    seer_read_path i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
        .chip_select_i(cs), .write_protect_i(wp), .write_busy_i(busy),
        .ident_locked_i(locked), .protect_size_i(ps), .mem_addr_o(maddr),
        .mem_ident_o(mid), .mem_data_i(mem_f(mid, maddr)),
        .serial_number_i(sn), .addr_load_o(ld), .addr_val_o(av));
    // keep the counter value handed over with the load pulse
    always @(posedge ref_clk_i) if (ld) av_seen <= av;
    seer_mst_model i_mst (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_o(msda));
    // array and page patterns differ so a wrong space shows
    function automatic logic [7:0] mem_f(input logic id, input logic [15:0] p);
        return id ? {1'b1, p[6:0]} ^ 8'h3c : p[7:0] ^ p[15:8] ^ 8'h96;
    endfunction : mem_f
    function automatic logic [7:0] exp_f(input logic [3:0] ty,
                                         input logic [15:0] s, input int i);
        logic [15:0] p;
        p = s + 16'(i);
        if (ty == TA) return mem_f(1'b0, p);
        if (s[10:9] == seer_pkg::SEER_SP_IDENT) return mem_f(1'b1, p);
        if (s[10:9] == seer_pkg::SEER_SP_SERIAL)
            return 8'(sn >> (8 * (15 - int'(p[3:0]))));
        return {6'h00, ps};
    endfunction : exp_f
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // optional dummy write, then a read of n bytes, last one refused
    task automatic xfer(input logic [3:0] ty, input logic [15:0] s,
                        input int n, input logic rnd);
        if (rnd) begin
            i_mst.start_c();
            i_mst.wbyte({ty, cs, 1'b0}, a);
            i_mst.wbyte(s[15:8], a);
            i_mst.wbyte(s[7:0], a);
            check({7'h00, a}, 8'h01);
            if (ty == TA) begin
                check(av_seen[15:8], s[15:8]);
                check(av_seen[7:0], s[7:0]);
            end
        end
        i_mst.start_c();
        i_mst.wbyte({ty, cs, 1'b1}, a);
        check({7'h00, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(rd, i < n - 1);
            check(rd, exp_f(ty, s, i));
        end
        i_mst.stop_c();
        i_mst.wait_clk(30);
    endtask : xfer
    task automatic probe(input logic [7:0] dev, input logic exp);
        i_mst.start_c();
        i_mst.wbyte(dev, a);
        check({7'h00, a}, {7'h00, exp});
        i_mst.stop_c();
        i_mst.wait_clk(30);
    endtask : probe
    // watchdog far beyond the expected run
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end
    initial begin
        sn = {$random(seed), $random(seed), $random(seed), $random(seed)};
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        i_mst.wait_clk(4);
        xfer(TA, 16'hfffe, 4, 1'b1);
        xfer(TA, 16'h0002, 2, 1'b0);
        xfer(TB, 16'h007e, 4, 1'b1);
        xfer(TA, 16'h0002, 1, 1'b0);
        xfer(TB, 16'h020e, 4, 1'b1);
        xfer(TB, 16'hfaf0, 17, 1'b1);
        for (int k = 0; k < 4; k++) begin
            ps = 2'(k);
            xfer(TB, 16'he6a5, 3, 1'b1);
        end
        probe({TA, cs ^ 3'h1, 1'b1}, 1'b0);
        probe({4'h9, cs, 1'b1}, 1'b0);
        busy = 1'b1;
        probe({TA, cs, 1'b1}, 1'b0);
        busy = 1'b0;
        for (int k = 0; k < 2; k++) begin
            locked = k[0];
            i_mst.start_c();
            i_mst.wbyte({TB, cs, 1'b0}, a);
            i_mst.wbyte(8'h00, a);
            i_mst.wbyte(8'h10, a);
            i_mst.wbyte(8'($random(seed)), a);
            check({7'h00, a}, {7'h00, !locked});
            i_mst.start_c();
            i_mst.stop_c();
            i_mst.wait_clk(30);
            xfer(TA, 16'h1234, 2, 1'b1);
        end
        repeat (8) begin
            wp = 1'($random(seed));
            ps = 2'($random(seed));
            ad = 16'($random(seed));
            t = ($random(seed) & 1) ? TB : TA;
            if (ad[10:9] == seer_pkg::SEER_SP_LOCK) ad[9] = 1'b1;
            xfer(t, ad, 1 + ($unsigned($random(seed)) % 4), 1'b1);
        end
        end_of_test();
    end
endmodule : seer_read_path_tb
`default_nettype wire
